// ---- design/char_port_pkg.sv ----
package char_port_pkg;

	// Clock rate and memory geometry
	localparam int          CLK_MHZ         = 20;
	localparam int          DISP_DEPTH      = 128;
	localparam int          DISP_AW         = 7;
	localparam int          GLYPH_DEPTH     = 64;
	localparam int          GLYPH_AW        = 6;
	localparam int          BUS_W           = 8;

	// Synchroniser bit positions for the pin bundle
	localparam int          PIN_SEL         = 10;
	localparam int          PIN_RNW         = 9;
	localparam int          PIN_EN          = 8;
	localparam int          PIN_W           = 11;

	// Instruction decode: the highest set bit picks the instruction
	localparam int          OP_DISP_ADDR    = 7;
	localparam int          OP_GLYPH_ADDR   = 6;
	localparam int          OP_FUNC_SET     = 5;
	localparam int          OP_SHIFT        = 4;
	localparam int          OP_DISP_CTRL    = 3;
	localparam int          OP_ENTRY        = 2;
	localparam int          OP_HOME         = 1;
	localparam int          OP_CLEAR        = 0;
	localparam int          FLD_TWO_LINE    = 3;
	localparam int          FLD_SHIFT_DISP  = 3;
	localparam int          FLD_SHIFT_RIGHT = 2;
	localparam int          FLD_ENTRY_INC   = 1;
	localparam int          FLD_ENTRY_SHIFT = 0;

	// Reset values and fill code
	localparam logic [7:0]  SPACE_CODE      = 8'h20;
	localparam logic [6:0]  ADDR_RST        = 7'h00;
	localparam logic [6:0]  ADDR_LAST       = 7'h7F;
	localparam logic [6:0]  SHIFT_RST       = 7'h00;
	localparam logic        INC_RST         = 1'b1;

	// Internal operation times and their cycle counts
	localparam int          SHORT_BUSY_NS   = 2000;
	localparam int          LONG_BUSY_NS    = 1520000;
	localparam int          SHORT_BUSY_CYC  = (SHORT_BUSY_NS * CLK_MHZ + 999) / 1000;
	localparam int          LONG_BUSY_CYC   = (LONG_BUSY_NS * CLK_MHZ + 999) / 1000;
	localparam int          CNT_W           = 16;

	// Controller sequencing
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_BUSY  = 2'b01,
		ST_CLEAR = 2'b10
	} ctl_state_t;

endpackage : char_port_pkg

// ---- design/byte_store.sv ----
`timescale 1ns/10ps
`default_nettype none

// Flip-flop byte array: one write port, two registered read ports
module byte_store #(
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	// Clock
	input  wire logic          clk,
	// Write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	// Read port a
	input  wire logic [AW-1:0] rd_a_addr,
	output var  logic [7:0]    rd_a_q,
	// Read port b
	input  wire logic [AW-1:0] rd_b_addr,
	output var  logic [7:0]    rd_b_q
);

	logic [7:0] mem_q [DEPTH];   // Storage, no reset: contents undefined until written

	// Both read ports register on every edge; storage only on edges with wr_en high
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
		rd_a_q <= mem_q[rd_a_addr];
		rd_b_q <= mem_q[rd_b_addr];
	end

endmodule : byte_store
`default_nettype wire

// ---- design/char_display_host_port.sv ----
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Select low targets instruction, high targets data
// - Select low, write: byte becomes an instruction
// - Select low, read: busy on bit7, address below
// - Data write stores byte at current address
// - Data read loads memory byte for the host
// - Only the host port writes instructions
// - Data register holds each byte the host reads or writes
// - Busy holds one and refuses further instructions
// - Busy clears when the operation finishes
// - Address instruction loads counter, picks memory
// - Each data access steps address by one
// - Display memory is 128 bytes, seven-bit address
// - One-line positions map to addresses 00..7F
// - Shifts offset positions, right wraps to 7F
// - Two-line mode uses 00..3F and 40..7F
module char_display_host_port
	import char_port_pkg::*;
#(
	parameter logic [CNT_W-1:0] SHORT_CYC = CNT_W'(SHORT_BUSY_CYC),
	parameter logic [CNT_W-1:0] LONG_CYC  = CNT_W'(LONG_BUSY_CYC)
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// Host port pins
	input  wire logic                register_select,
	input  wire logic                read_not_write,
	input  wire logic                enable,
	input  wire logic [BUS_W-1:0]    data_bus_in,
	output var  logic [BUS_W-1:0]    data_bus_out_q,
	output var  logic                data_bus_oe_q,
	// State shown to the panel side
	output var  logic                busy_flag_q,
	output var  logic                two_line_q,
	// Display scan port
	input  wire logic [DISP_AW-1:0]  scan_pos,
	output var  logic [7:0]          scan_code_q,
	// Glyph scan port
	input  wire logic [GLYPH_AW-1:0] glyph_scan_addr,
	output var  logic [7:0]          glyph_row_q
);

	// Pin synchroniser; only the second stage is ever read
	logic [PIN_W-1:0]   pin_meta_q;
	logic [PIN_W-1:0]   pin_sync_q;
	logic               en_prev_q;        // Previous synced enable, for edges
	// Controller state
	ctl_state_t         state_q, state_d;
	logic [CNT_W-1:0]   cnt_q, cnt_d;     // Remaining busy cycles
	logic [DISP_AW-1:0] addr_q, addr_d;   // address_counter
	logic               glyph_q, glyph_d; // Counter points into glyph memory
	logic               inc_q, inc_d;     // Step direction after access
	logic               eshift_q, eshift_d; // Shift display on each data write to display memory
	logic               two_line_d;
	logic [DISP_AW-1:0] shift_q, shift_d; // Display shift offset
	logic [7:0]         data_q, data_d;   // data_register
	logic [7:0]         instr_q, instr_d; // instruction_register
	logic [DISP_AW-1:0] clr_idx_q, clr_idx_d;
	logic [BUS_W-1:0]   dout_d;
	logic               doe_d;
	// Memory ports
	logic               disp_we, glyph_we;
	logic [DISP_AW-1:0] disp_wa;
	logic [7:0]         mem_wd;
	logic [7:0]         disp_host_rd, glyph_host_rd;
	logic [DISP_AW-1:0] scan_addr;
	// Decoded pins
	logic sel_s, rnw_s, en_s, en_rise, en_fall, idle;
	logic [BUS_W-1:0] bus_s;
	assign sel_s   = pin_sync_q[PIN_SEL];
	assign rnw_s   = pin_sync_q[PIN_RNW];
	assign en_s    = pin_sync_q[PIN_EN];
	assign bus_s   = pin_sync_q[BUS_W-1:0];
	assign en_rise = en_s & ~en_prev_q;
	assign en_fall = ~en_s & en_prev_q;
	assign idle    = (state_q == ST_IDLE);
	// Next address after an access; glyph addresses wrap within six bits
	function automatic logic [DISP_AW-1:0] step_addr(input logic [DISP_AW-1:0] a,
		input logic up, input logic in_glyph);
		logic [DISP_AW-1:0] n;
		n = up ? DISP_AW'(a + 7'h01) : DISP_AW'(a - 7'h01);
		return in_glyph ? {1'b0, n[GLYPH_AW-1:0]} : n;
	endfunction : step_addr
	// Pins arrive from another domain, so two flops before any use
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
			en_prev_q  <= 1'b0;
		end else begin
			pin_meta_q <= {register_select, read_not_write, enable, data_bus_in};
			pin_sync_q <= pin_meta_q;
			en_prev_q  <= pin_sync_q[PIN_EN];
		end
	end

	// Controller next state: accesses complete on the enable falling edge
	always_comb begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		addr_d     = addr_q;
		glyph_d    = glyph_q;
		inc_d      = inc_q;
		eshift_d   = eshift_q;
		two_line_d = two_line_q;
		shift_d    = shift_q;
		data_d     = data_q;
		instr_d    = instr_q;
		clr_idx_d  = clr_idx_q;
		disp_we    = 1'b0;
		glyph_we   = 1'b0;
		disp_wa    = addr_q;
		mem_wd     = bus_s;
		case (state_q)
			ST_IDLE: begin
				if (en_rise && sel_s && rnw_s) begin
					// Stage the byte at the counter for the host to read
					data_d = glyph_q ? glyph_host_rd : disp_host_rd;
				end
				if (en_fall && !rnw_s && !sel_s) begin
					// Instruction write, only from the host pins
					instr_d = bus_s;
					state_d = ST_BUSY;
					cnt_d   = SHORT_CYC;
					if (bus_s[OP_DISP_ADDR]) begin
						addr_d  = bus_s[DISP_AW-1:0];
						glyph_d = 1'b0;
					end else if (bus_s[OP_GLYPH_ADDR]) begin
						addr_d  = {1'b0, bus_s[GLYPH_AW-1:0]};
						glyph_d = 1'b1;
					end else if (bus_s[OP_FUNC_SET]) begin
						two_line_d = bus_s[FLD_TWO_LINE];
					end else if (bus_s[OP_SHIFT]) begin
						if (bus_s[FLD_SHIFT_DISP]) begin
							// Right lowers the offset, wrapping 00 to 7F
							shift_d = bus_s[FLD_SHIFT_RIGHT] ? DISP_AW'(shift_q - 7'h01)
							                                 : DISP_AW'(shift_q + 7'h01);
						end else begin
							addr_d = step_addr(addr_q, !bus_s[FLD_SHIFT_RIGHT], glyph_q);
						end
					end else if (bus_s[OP_DISP_CTRL]) begin
						// Display on/off and cursor live in the panel driver
						cnt_d = SHORT_CYC;
					end else if (bus_s[OP_ENTRY]) begin
						inc_d    = bus_s[FLD_ENTRY_INC];
						eshift_d = bus_s[FLD_ENTRY_SHIFT];
					end else if (bus_s[OP_HOME]) begin
						addr_d  = ADDR_RST;
						glyph_d = 1'b0;
						shift_d = SHIFT_RST;
						cnt_d   = LONG_CYC;
					end else if (bus_s[OP_CLEAR]) begin
						// Fill walks every display byte, one per cycle
						addr_d    = ADDR_RST;
						glyph_d   = 1'b0;
						inc_d     = INC_RST;
						shift_d   = SHIFT_RST;
						clr_idx_d = ADDR_RST;
						state_d   = ST_CLEAR;
					end
				end else if (en_fall && !rnw_s && sel_s) begin
					// Data write loads the data register and memory from the bus in the same cycle
					data_d   = bus_s;
					disp_we  = !glyph_q;
					glyph_we = glyph_q;
					addr_d   = step_addr(addr_q, inc_q, glyph_q);
					if (eshift_q && !glyph_q) begin
						shift_d = inc_q ? DISP_AW'(shift_q + 7'h01) : DISP_AW'(shift_q - 7'h01);
					end
					state_d = ST_BUSY;
					cnt_d   = SHORT_CYC;
				end else if (en_fall && rnw_s && sel_s) begin
					// Read completes: counter moves on for the next one
					addr_d  = step_addr(addr_q, inc_q, glyph_q);
					state_d = ST_BUSY;
					cnt_d   = SHORT_CYC;
				end
			end
			ST_BUSY: begin
				// Writes in this state are dropped; status reads still work
				if (cnt_q <= CNT_W'(1)) begin
					state_d = ST_IDLE;
				end else begin
					cnt_d = CNT_W'(cnt_q - 16'h0001);
				end
			end
			ST_CLEAR: begin
				disp_we   = 1'b1;
				disp_wa   = clr_idx_q;
				mem_wd    = SPACE_CODE;
				clr_idx_d = DISP_AW'(clr_idx_q + 7'h01);
				if (clr_idx_q == ADDR_LAST) begin
					state_d = ST_BUSY;
					cnt_d   = LONG_CYC;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Controller registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q    <= ST_IDLE;
			cnt_q      <= '0;
			addr_q     <= ADDR_RST;
			glyph_q    <= 1'b0;
			inc_q      <= INC_RST;
			eshift_q   <= 1'b0;
			two_line_q <= 1'b0;
			shift_q    <= SHIFT_RST;
			data_q     <= 8'h00;
			instr_q    <= 8'h00;
			clr_idx_q  <= ADDR_RST;
			busy_flag_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			addr_q     <= addr_d;
			glyph_q    <= glyph_d;
			inc_q      <= inc_d;
			eshift_q   <= eshift_d;
			two_line_q <= two_line_d;
			shift_q    <= shift_d;
			data_q     <= data_d;
			instr_q    <= instr_d;
			clr_idx_q  <= clr_idx_d;
			busy_flag_q <= (state_d != ST_IDLE);
		end
	end

	// Bus driver: the pin lags three cycles behind enable, a trade for safe sampling
	always_comb begin
		doe_d = en_s && rnw_s;
		if (sel_s) begin
			dout_d = (en_rise && idle) ? (glyph_q ? glyph_host_rd : disp_host_rd) : data_q;
		end else begin
			dout_d = {busy_flag_q, addr_q};
		end
	end

	// Bus driver registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_bus_out_q <= 8'h00;
			data_bus_oe_q  <= 1'b0;
		end else begin
			data_bus_out_q <= dout_d;
			data_bus_oe_q  <= doe_d;
		end
	end

	// Position to address: two-line keeps the line bit, shift wraps in 64
	always_comb begin
		if (two_line_q) begin
			scan_addr = {scan_pos[DISP_AW-1],
			             GLYPH_AW'(scan_pos[GLYPH_AW-1:0] + shift_q[GLYPH_AW-1:0])};
		end else begin
			scan_addr = DISP_AW'(scan_pos + shift_q);
		end
	end

	// Display memory: 128 character codes on a seven-bit address
	byte_store #(.DEPTH(DISP_DEPTH), .AW(DISP_AW)) u_disp (
		.clk       (clk),
		.wr_en     (disp_we),
		.wr_addr   (disp_wa),
		.wr_data   (mem_wd),
		.rd_a_addr (addr_q),
		.rd_a_q    (disp_host_rd),
		.rd_b_addr (scan_addr),
		.rd_b_q    (scan_code_q)
	);

	// Glyph memory: user patterns, six-bit address
	byte_store #(.DEPTH(GLYPH_DEPTH), .AW(GLYPH_AW)) u_glyph (
		.clk       (clk),
		.wr_en     (glyph_we),
		.wr_addr   (addr_q[GLYPH_AW-1:0]),
		.wr_data   (mem_wd),
		.rd_a_addr (addr_q[GLYPH_AW-1:0]),
		.rd_a_q    (glyph_host_rd),
		.rd_b_addr (glyph_scan_addr),
		.rd_b_q    (glyph_row_q)
	);

	// Checks on the controller
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_instr_wr;
		idle && en_fall && !rnw_s && !sel_s;
	endsequence
	sequence s_data_wr;
		idle && en_fall && !rnw_s && sel_s;
	endsequence
	sequence s_clear_last;
		state_q == ST_CLEAR && clr_idx_q == ADDR_LAST;
	endsequence
	chk_status_read: assert property (
		data_bus_oe_q && !$past(sel_s) |-> data_bus_out_q == {$past(busy_flag_q), $past(addr_q)})
		else $error("status read shows wrong busy or address");
	chk_addr_load: assert property (
		s_instr_wr and bus_s[OP_DISP_ADDR] |=> addr_q == $past(bus_s[DISP_AW-1:0]) && !glyph_q)
		else $error("address instruction did not load the counter");
	chk_busy_raise: assert property (
		(s_instr_wr or s_data_wr) |=> busy_flag_q ##1 busy_flag_q)
		else $error("busy not raised after an accepted write");
	chk_busy_refuse: assert property (
		state_q == ST_BUSY && en_fall && !rnw_s && !sel_s |=> $stable(instr_q) && $stable(addr_q))
		else $error("instruction accepted while busy");
	chk_busy_clear: assert property (
		state_q == ST_BUSY && cnt_q == CNT_W'(1) |=> !busy_flag_q && idle)
		else $error("busy did not clear at end of operation");
	chk_addr_step: assert property (
		s_data_wr and (inc_q && !glyph_q) |=> addr_q == DISP_AW'($past(addr_q) + 7'h01))
		else $error("address did not step after data write");
	chk_data_write: assert property (
		s_data_wr and !glyph_q |-> disp_we && disp_wa == addr_q && mem_wd == bus_s)
		else $error("data write missed display memory");
	chk_read_stage: assert property (
		idle && en_rise && sel_s && rnw_s && !glyph_q |=> data_q == $past(disp_host_rd))
		else $error("data read did not stage the memory byte");
	chk_shift_wrap: assert property (
		s_instr_wr and (bus_s[7:4] == 4'h1 && bus_s[3:2] == 2'h3 && shift_q == SHIFT_RST)
		|=> shift_q == ADDR_LAST)
		else $error("right shift did not wrap to the last address");
	chk_clear_end: assert property (
		s_clear_last |=> state_q == ST_BUSY ##1 busy_flag_q)
		else $error("clear fill did not hand over to busy wait");
endmodule : char_display_host_port
`default_nettype wire

// ---- verif/host_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// Host processor on the eight-bit pin port
module host_cpu_model
	import char_port_pkg::*;
(
	// Clock
	input  wire logic             clk,
	// Pins toward the port
	output var  logic             register_select,
	output var  logic             read_not_write,
	output var  logic             enable,
	output var  logic [BUS_W-1:0] data_bus_in,
	// Pins from the port
	input  wire logic [BUS_W-1:0] data_bus_out_q,
	input  wire logic             data_bus_oe_q
);
	localparam int HOLD = 6;     // Strobe phase length, above the synchroniser delay
	logic [7:0]    last_q;       // Last byte the host drove
	logic          rd_oe;        // Device drive seen during the last access

	initial begin
		register_select = 1'b0;
		read_not_write  = 1'b1;
		enable          = 1'b0;
		data_bus_in     = 8'h00;
		last_q          = 8'h00;
		rd_oe           = 1'b0;
	end

	// One pin cycle; a released bus shows the inverse so stale data cannot pass
	task automatic access(input logic rs, input logic rnw, input logic [7:0] wd,
		output logic [7:0] rd);
		@(negedge clk);
		register_select = rs;
		read_not_write  = rnw;
		data_bus_in     = rnw ? ~last_q : wd;
		if (!rnw) last_q = wd;
		@(negedge clk);
		enable = 1'b1;
		repeat (HOLD) @(negedge clk);
		rd     = data_bus_out_q;
		rd_oe  = data_bus_oe_q;
		enable = 1'b0;
		repeat (HOLD) @(negedge clk);
		data_bus_in = ~last_q;
	endtask : access

	// Poll status until idle, bounded so a stuck busy cannot hang the host
	task automatic wait_ready(output logic [7:0] st, output logic ok);
		ok = 1'b0;
		for (int i = 0; i < 100 && !ok; i++) begin
			access(1'b0, 1'b1, 8'h00, st);
			ok = (st[7] === 1'b0);
		end
	endtask : wait_ready

endmodule : host_cpu_model

`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb
	import char_port_pkg::*;
;
	// Pins and scan ports
	logic       clk, sys_rst, register_select, read_not_write, enable;
	logic [7:0] data_bus_in, data_bus_out_q, scan_code_q, glyph_row_q;
	logic       data_bus_oe_q, busy_flag_q, two_line_q;
	logic [6:0] scan_pos;
	logic [5:0] glyph_scan_addr;
	// Bench state
	int         error_cnt, samples_checked, seed;
	logic [7:0] mem_q [128];     // Expected display contents
	logic [7:0] st, rd, b;
	logic       ok, inc, ac_ok, two;
	logic [6:0] ac, off;         // Expected address and shift offset
	logic [5:0] g;

	char_display_host_port #(.SHORT_CYC(16'h0028), .LONG_CYC(16'h00C8))
	char_display_host_port_inst (.clk(clk), .sys_rst(sys_rst),
		.register_select(register_select), .read_not_write(read_not_write),
		.enable(enable), .data_bus_in(data_bus_in), .data_bus_out_q(data_bus_out_q),
		.data_bus_oe_q(data_bus_oe_q), .busy_flag_q(busy_flag_q), .two_line_q(two_line_q),
		.scan_pos(scan_pos), .scan_code_q(scan_code_q),
		.glyph_scan_addr(glyph_scan_addr), .glyph_row_q(glyph_row_q));

	host_cpu_model host_cpu_model_inst (.clk(clk), .register_select(register_select),
		.read_not_write(read_not_write), .enable(enable), .data_bus_in(data_bus_in),
		.data_bus_out_q(data_bus_out_q), .data_bus_oe_q(data_bus_oe_q));

	// Clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Display address that a position shows, per line mode and shift
	function automatic logic [6:0] daddr(input logic [6:0] p);
		return two ? {p[6], 6'(p[5:0] + off[5:0])} : 7'(p + off);
	endfunction : daddr

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
		samples_checked++;
		if (v !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, v);
			error_cnt++;
		end
	endtask : chk

	task automatic test_done;
		if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done

	// Wait for idle; the last status must carry the modelled address
	task automatic ready;
		host_cpu_model_inst.wait_ready(st, ok);
		chk("ready", 8'h01, {7'h00, ok});
		if (ac_ok) chk("status", {1'b0, ac}, st);
		chk("busy pin", 8'h00, {7'h00, busy_flag_q});
	endtask : ready

	task automatic cmd(input logic [7:0] c);
		ready;
		host_cpu_model_inst.access(1'b0, 1'b0, c, rd);
	endtask : cmd

	task automatic setad(input logic [6:0] a);
		cmd({1'b1, a});
		ac = a;
	endtask : setad

	// Data write; the expected address only moves in display mode
	task automatic wr(input logic [7:0] d);
		ready;
		host_cpu_model_inst.access(1'b1, 1'b0, d, rd);
		if (ac_ok) begin
			mem_q[ac] = d;
			ac = inc ? ac + 7'h01 : ac - 7'h01;
		end
	endtask : wr

	task automatic rdd;
		ready;
		host_cpu_model_inst.access(1'b1, 1'b1, 8'h00, rd);
		chk("data", mem_q[ac], rd);
		chk("drive", 8'h01, {7'h00, host_cpu_model_inst.rd_oe});
		ac = inc ? ac + 7'h01 : ac - 7'h01;
	endtask : rdd

	task automatic scan(input logic [6:0] p);
		scan_pos = p;
		repeat (2) @(negedge clk);
		chk("scan", mem_q[daddr(p)], scan_code_q);
	endtask : scan

	// Watchdog
	initial begin
		#(40000 * 50);
		error_cnt++;
		test_done;
	end

	// Main sequence
	initial begin
		seed = 98765;
		{error_cnt, samples_checked} = '0;
		{sys_rst, inc, ac_ok, two} = 4'b1110;
		{scan_pos, glyph_scan_addr, ac, off} = '0;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		ready;
		// Fill all 128 entries; the counter must wrap back to 00
		setad(7'h00);
		for (int i = 0; i < 128; i++) wr(8'($random(seed)));
		ready;
		// A write while busy must be refused
		wr(8'h5A);
		host_cpu_model_inst.access(1'b0, 1'b1, 8'h00, rd);
		chk("busy", 8'h01, {7'h00, rd[7]});
		chk("busy pin", 8'h01, {7'h00, busy_flag_q});
		host_cpu_model_inst.access(1'b1, 1'b0, 8'hA5, rd);
		ready;
		// An address instruction inside the busy time must not move the counter
		setad(7'h00);
		host_cpu_model_inst.access(1'b0, 1'b0, 8'h90, rd);
		for (int i = 0; i < 6; i++) rdd;
		for (int i = 0; i < 8; i++) scan(7'($random(seed)));
		scan(7'h7F);
		// Cursor move with the direction bit clear steps the counter up
		cmd(8'h10);
		ac = ac + 7'h01;
		// Display control touches neither counter nor offset
		cmd(8'h0C);
		// Shift left, then right twice: first position shows 7F
		cmd(8'h18);
		off = off + 7'h01;
		scan(7'h00);
		scan(7'h7F);
		cmd(8'h1C);
		cmd(8'h1C);
		off = off - 7'h02;
		scan(7'h00);
		// Decrement entry mode
		cmd(8'h04);
		inc = 1'b0;
		setad(7'h10);
		wr(8'($random(seed)));
		wr(8'($random(seed)));
		rdd;
		cmd(8'h06);
		inc = 1'b1;
		// Two-line layout
		cmd(8'h28);
		two = 1'b1;
		ready;
		chk("lines", 8'h01, {7'h00, two_line_q});
		scan(7'h40);
		scan(7'h3F);
		cmd(8'h02);
		{ac, off} = '0;
		scan(7'($random(seed)));
		// Glyph memory through its own address instruction
		ac_ok = 1'b0;
		for (int i = 0; i < 3; i++) begin
			g = 6'($random(seed));
			b = 8'($random(seed));
			cmd({2'b01, g});
			wr(b);
			glyph_scan_addr = g;
			repeat (2) @(negedge clk);
			chk("glyph", b, glyph_row_q);
		end
		// Clear fills spaces and homes the address
		cmd(8'h01);
		ac_ok = 1'b1;
		ac = 7'h00;
		foreach (mem_q[i]) mem_q[i] = SPACE_CODE;
		ready;
		scan(7'($random(seed)));
		test_done;
	end

endmodule : tb

`default_nettype wire
